// [pmfc_pkg.sv]
// Package: constants and types for the pager message format converter
// Contract
// - Format from options and function bits
// - Alphanumeric: 7-bit characters plus error flag
// - Alphanumeric characters cross codeword boundaries
// - Numeric nibbles mapped to ASCII table
// - 4-bit package: nibble low, status high
// - Raw: 8-bit blocks, last nibble with status
// - Option bits and package select pick format
// - Function bits zero give numeric, else alpha
// - Report option: status bits in 4..7
// - Report clear: status field 0,1,1,flag
// - Status order: parity, pre, burst, random
package pmfc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] PMFC_CTRL_OFFSET = 8'h00;
  localparam logic [7:0] PMFC_STATUS_OFFSET = 8'h04;
  localparam logic [4:0] PMFC_CTRL_RESET = 5'h00;
  localparam logic [1:0] PMFC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PMFC_RESP_SLVERR = 2'h2;

  // ==========================================================
  // Bit stream geometry
  localparam logic [5:0] PMFC_MSG_BITS = 6'h14;
  localparam logic [5:0] PMFC_ALPHA_W = 6'h07;
  localparam logic [5:0] PMFC_NIB_W = 6'h04;
  localparam logic [5:0] PMFC_RAW_W = 6'h08;
  localparam logic [2:0] PMFC_PLAIN_ER = 3'h6;

  // ==========================================================
  // Types
  // Output format of the current message
  typedef enum logic [1:0] {PMFC_NUM_ASCII, PMFC_NUM_PKG4, PMFC_ALPHA7, PMFC_RAW8} pmfc_mode_t;
  // Converter sequencing
  typedef enum logic {PMFC_IDLE, PMFC_EMIT} pmfc_state_t;
  // One codeword from the decoder
  typedef struct packed {
    logic first;
    logic [1:0] func;
    logic [19:0] msg;
    logic [3:0] status;
    logic err_flag;
  } pmfc_cw_t;
  // Control register fields, bit 0 upward: a, b, package, report, raw
  typedef struct packed {
    logic raw;
    logic error_report_mode;
    logic package_select;
    logic format_select_b;
    logic format_select_a;
  } pmfc_cfg_t;

endpackage : pmfc_pkg

// [pmfc_axil.sv]
// AXI4-Lite register slave for the format converter
`timescale 1ns/1ns
`default_nettype none
module pmfc_axil
  import pmfc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Block side
  output pmfc_cfg_t cfg,
  input wire logic [8:0] status_word
);

  // ==========================================================
  // State
  logic [7:0] aw_addr, next_aw_addr; // Held write address
  logic [31:0] w_data, next_w_data; // Held write data
  logic w_lane0, next_w_lane0; // Low byte strobe
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  pmfc_cfg_t next_cfg;

  // Next values of both channel groups
  always_comb begin
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_awready = s_axi_awready;
    next_wready = s_axi_wready;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_cfg = cfg;
    // Address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_awready = 1'b0;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wready = 1'b0;
      next_w_data = s_axi_wdata;
      next_w_lane0 = s_axi_wstrb[0];
    end
    // Both halves held: perform the write
    if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
      next_bvalid = 1'b1;
      next_bresp = PMFC_RESP_OKAY;
      if (aw_addr == PMFC_CTRL_OFFSET) begin
        if (w_lane0) begin
          next_cfg = pmfc_cfg_t'(w_data[4:0]);
        end
      end else if (aw_addr != PMFC_STATUS_OFFSET) begin
        next_bresp = PMFC_RESP_SLVERR;
      end
    end
    // Response taken: open for the next write
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
    // Read decode
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = PMFC_RESP_OKAY;
      if (s_axi_araddr == PMFC_CTRL_OFFSET) begin
        next_rdata = {27'h0, cfg};
      end else if (s_axi_araddr == PMFC_STATUS_OFFSET) begin
        next_rdata = {23'h0, status_word};
      end else begin
        next_rdata = 32'h0;
        next_rresp = PMFC_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  // Register stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PMFC_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= PMFC_RESP_OKAY;
      cfg <= pmfc_cfg_t'(PMFC_CTRL_RESET);
    end else begin
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      cfg <= next_cfg;
    end
  end

endmodule : pmfc_axil
`default_nettype wire

// [pmfc_converter.sv]
// Pager message format converter: codewords in, message words out
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module pmfc_converter
  import pmfc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Codewords from the decoder
  input wire logic cw_valid,
  input wire pmfc_cw_t cw,
  output logic cw_ready,
  // Message words toward the host
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // Declarations
  pmfc_cfg_t cfg; // Software options
  pmfc_state_t state, next_state; // Sequencer
  pmfc_mode_t mode, next_mode; // Format of current message
  logic [31:0] acc, next_acc; // Pending message bits, oldest at bit 0
  logic [5:0] cnt, next_cnt; // Pending bit count
  logic [5:0] old_cnt, next_old_cnt; // Pending bits from earlier codeword
  logic old_flag, next_old_flag; // Error flag of those bits
  logic flag, next_flag; // Error flag of latest codeword
  logic [3:0] stat, next_stat; // Status bits of latest codeword
  logic next_cw_ready, next_out_valid;
  logic [7:0] next_out_data;
  logic cw_fire; // Codeword taken
  pmfc_mode_t cur_mode; // Format applying to the offered codeword
  logic [5:0] unit, take; // Word width and bits consumed
  logic have_word; // Another word is ready
  logic [7:0] word; // Formatted word
  logic [31:0] base_acc;
  logic [5:0] base_cnt;

  // ==========================================================
  // Register slave
  pmfc_axil u_axil (
    .clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .cfg(cfg),
    .status_word({cnt, mode, state == PMFC_EMIT})
  );

  // ==========================================================
  // Helpers
  // Numeric digit to ASCII character
  function automatic logic [6:0] num_char(input logic [3:0] n);
    case (n)
      4'ha: num_char = 7'h2a;
      4'hb: num_char = 7'h55;
      4'hc: num_char = 7'h20;
      4'hd: num_char = 7'h2d;
      4'he: num_char = 7'h5d;
      4'hf: num_char = 7'h5b;
      default: num_char = {3'h3, n};
    endcase
  endfunction : num_char

  // Format from options and function bits
  function automatic pmfc_mode_t pick_mode(input pmfc_cfg_t c, input logic [1:0] f);
    logic [1:0] sel;
    sel = {c.format_select_a, c.format_select_b};
    if (c.raw) begin
      pick_mode = PMFC_RAW8;
    end else if (c.package_select) begin
      pick_mode = (sel == 2'h0) ? PMFC_NUM_ASCII : PMFC_ALPHA7;
    end else begin
      case (sel)
        2'h0: pick_mode = PMFC_NUM_PKG4;
        2'h1: pick_mode = PMFC_NUM_ASCII;
        2'h2: pick_mode = PMFC_ALPHA7;
        default: pick_mode = (f == 2'h0) ? PMFC_NUM_ASCII : PMFC_ALPHA7;
      endcase
    end
  endfunction : pick_mode

  // ==========================================================
  // Word formatting
  always_comb begin
    cw_fire = cw_valid && cw_ready;
    cur_mode = cw.first ? pick_mode(cfg, cw.func) : mode;
    case (mode)
      PMFC_ALPHA7: unit = PMFC_ALPHA_W;
      PMFC_RAW8: unit = PMFC_RAW_W;
      default: unit = PMFC_NIB_W;
    endcase
    // Raw mode flushes a short tail; other modes need a whole unit
    have_word = (mode == PMFC_RAW8) ? (cnt != 6'h00) : (cnt >= unit);
    take = (cnt < unit) ? cnt : unit;
    case (mode)
      // Earliest bit sits in acc bit 0 and lands in word bit 0
      PMFC_NUM_ASCII: word = {flag, num_char(acc[3:0])};
      PMFC_NUM_PKG4: begin
        if (cfg.error_report_mode) begin
          word = {stat, acc[3:0]};
        end else begin
          word = {flag, PMFC_PLAIN_ER, acc[3:0]};
        end
      end
      PMFC_ALPHA7: word = {flag | ((old_cnt != 6'h00) && old_flag), acc[6:0]};
      default: begin
        if (cnt == PMFC_NIB_W) begin
          word = {stat, acc[3:0]};
        end else begin
          word = acc[7:0];
        end
      end
    endcase
  end

  // ==========================================================
  // Sequencer next values
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_acc = acc;
    next_cnt = cnt;
    next_old_cnt = old_cnt;
    next_old_flag = old_flag;
    next_flag = flag;
    next_stat = stat;
    next_out_valid = out_valid && !out_ready;
    next_out_data = out_data;
    base_acc = cw.first ? 32'h0 : acc;
    base_cnt = cw.first ? 6'h00 : cnt;
    case (state)
      // Append a codeword behind leftover bits; a first codeword drops them
      PMFC_IDLE: begin
        if (cw_fire) begin
          next_mode = cur_mode;
          next_acc = base_acc | ({12'h0, cw.msg} << base_cnt);
          next_cnt = base_cnt + PMFC_MSG_BITS;
          next_old_cnt = base_cnt;
          next_old_flag = flag;
          next_flag = cw.err_flag;
          next_stat = cw.status;
          next_state = PMFC_EMIT;
        end
      end
      // Emit words while whole units remain, or in raw mode while any bits remain
      PMFC_EMIT: begin
        if (!out_valid || out_ready) begin
          if (have_word) begin
            next_out_valid = 1'b1;
            next_out_data = word;
            next_acc = acc >> take;
            next_cnt = cnt - take;
            next_old_cnt = (old_cnt > take) ? old_cnt - take : 6'h00;
          end else begin
            next_state = PMFC_IDLE;
          end
        end
      end
      default: next_state = PMFC_IDLE;
    endcase
    next_cw_ready = (next_state == PMFC_IDLE);
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= PMFC_IDLE;
      mode <= PMFC_NUM_PKG4;
      acc <= 32'h0;
      cnt <= 6'h00;
      old_cnt <= 6'h00;
      old_flag <= 1'b0;
      flag <= 1'b0;
      stat <= 4'h0;
      cw_ready <= 1'b0;
      out_valid <= 1'b0;
      out_data <= 8'h00;
    end else begin
      state <= next_state;
      mode <= next_mode;
      acc <= next_acc;
      cnt <= next_cnt;
      old_cnt <= next_old_cnt;
      old_flag <= next_old_flag;
      flag <= next_flag;
      stat <= next_stat;
      cw_ready <= next_cw_ready;
      out_valid <= next_out_valid;
      out_data <= next_out_data;
    end
  end

  // ==========================================================
  // Checks
  pmfc_cw_t held; // Last codeword taken
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      held <= '0;
    end else if (cw_fire) begin
      held <= cw;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_mode_hold: assert property (!(cw_fire && cw.first) |=> $stable(mode))
    else $error("format changed without a new message");
  a_mode_options: assert property (cw_fire && cw.first && !cfg.raw && !cfg.package_select
      && !cfg.format_select_a && !cfg.format_select_b |=> mode == PMFC_NUM_PKG4)
    else $error("option pair zero did not pick 4-bit package");
  a_mode_function: assert property (cw_fire && cw.first && !cfg.raw && !cfg.package_select
      && cfg.format_select_a && cfg.format_select_b
      |=> mode == ((held.func == 2'h0) ? PMFC_NUM_ASCII : PMFC_ALPHA7))
    else $error("function bits picked the wrong format");
  a_alpha_first: assert property (cw_fire && cw.first && cur_mode == PMFC_ALPHA7
      |-> ##2 out_valid && out_data == {held.err_flag, held.msg[6:0]})
    else $error("first alphanumeric character wrong");
  a_alpha_carry: assert property (cw_fire && !cw.first && cur_mode == PMFC_ALPHA7
      |=> cnt == $past(cnt) + PMFC_MSG_BITS)
    else $error("leftover bits lost at codeword boundary");
  a_numeric_ascii: assert property (cw_fire && cw.first && cur_mode == PMFC_NUM_ASCII
      |-> ##2 out_valid && out_data == {held.err_flag, num_char(held.msg[3:0])})
    else $error("numeric character mapping wrong");
  a_pkg4_nibble: assert property (cw_fire && cw.first && cur_mode == PMFC_NUM_PKG4
      |-> ##2 out_valid && out_data[3:0] == held.msg[3:0])
    else $error("package nibble wrong");
  a_pkg4_report: assert property (cw_fire && cw.first && cur_mode == PMFC_NUM_PKG4
      && cfg.error_report_mode |-> ##2 out_data[7:4] == held.status)
    else $error("reported status bits misplaced");
  a_pkg4_plain: assert property (cw_fire && cw.first && cur_mode == PMFC_NUM_PKG4
      && !cfg.error_report_mode |-> ##2 out_data[7:4] == {held.err_flag, 3'h6})
    else $error("plain status field wrong");
  a_status_order: assert property (cw_fire && cw.first && cur_mode == PMFC_NUM_PKG4
      && cfg.error_report_mode |-> ##2 out_data[4] == held.status[0]
      && out_data[7] == held.status[3])
    else $error("status bit order wrong");
  a_raw_tail: assert property (state == PMFC_EMIT && mode == PMFC_RAW8 && out_valid
      && cnt == 6'h00 |-> out_data == {held.status, held.msg[19:16]})
    else $error("raw tail word wrong");
  a_raw_order: assert property (cw_fire && cw.first && cur_mode == PMFC_RAW8
      |-> ##2 out_valid && out_data == held.msg[7:0])
    else $error("raw first block not in received order");

  c_alpha_cross: cover property (cw_fire && !cw.first && mode == PMFC_ALPHA7 && cnt != 6'h00);
  c_raw_tail: cover property (mode == PMFC_RAW8 && out_valid && out_ready && cnt == 6'h00);
  c_stall: cover property (out_valid && !out_ready ##1 out_valid && out_ready);

endmodule : pmfc_converter
`default_nettype wire

// [pmfc_host_model.sv]
// Host model: takes message words from the converter, stalling on request
`timescale 1ns/1ns
`default_nettype none
module pmfc_host_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Message word stream
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready,
  // Test control: slow host when high
  input wire logic stall
);
  // Words taken, oldest first
  logic [7:0] got[$];

  // ==========================================================
  // Ready pattern and capture
  // A stalling host takes a word only every other cycle
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= stall ? ~out_ready : 1'b1;
      // Keep every word taken, in arrival order
      if (out_valid && out_ready) begin
        got.push_back(out_data);
      end
    end
  end
endmodule : pmfc_host_model
`default_nettype wire

// [tb_top.sv]
// Testbench: drives codewords and registers, checks the message words
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import pmfc_pkg::*;
();
  // One table row: control value, function bits, format expected
  typedef struct packed {
    logic [4:0] ctrl;
    logic [1:0] func;
    pmfc_mode_t mode;
  } pmfc_row_t;
  // ==========================================================
  // Signals
  logic clock, rst_n, cw_valid, cw_ready, out_valid, out_ready, stall;
  pmfc_cw_t cw;
  logic [7:0] out_data, awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  // Bench state: expected words and alphanumeric leftovers
  int err_total, n_tests, pend_n;
  logic [7:0] exp_q[$];
  pmfc_mode_t cur_mode;
  logic report, pend_flag;
  logic [6:0] pend;
  pmfc_row_t rows [13];

  pmfc_converter pmfc_converter_i (
    .clock(clock), .rst_n(rst_n), .cw_valid(cw_valid), .cw(cw), .cw_ready(cw_ready),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  pmfc_host_model pmfc_host_model_i (
    .clock(clock), .rst_n(rst_n), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .stall(stall));

  // Clock at 4 ns
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ==========================================================
  // Report tasks
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic timeout(input string what);
    err_total++;
    $display("CHECK FAILED %s expected handshake seen timeout", what);
    results();
  endtask : timeout

  // ==========================================================
  // Register bus tasks
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] want);
    int i;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      // Release each channel once it is taken
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        check("bresp", 32'(bresp), 32'(want));
        return;
      end
    end
    timeout("write");
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    int i;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        return;
      end
    end
    timeout("read");
  endtask : axi_read

  // ==========================================================
  // Expected words
  function automatic logic [6:0] asc(input logic [3:0] n);
    case (n)
      4'ha: return 7'h2a;
      4'hb: return 7'h55;
      4'hc: return 7'h20;
      4'hd: return 7'h2d;
      4'he: return 7'h5d;
      4'hf: return 7'h5b;
      default: return 7'h30 + 7'(n);
    endcase
  endfunction : asc

  task automatic expect_cw(input logic first, input logic [19:0] m, input logic [3:0] st,
      input logic fl);
    logic [26:0] b;
    logic f;
    int k;
    // A new message drops any leftover alphanumeric bits
    if (first) begin
      pend_n = 0;
      pend = 7'h00;
    end
    case (cur_mode)
      PMFC_NUM_ASCII: for (k = 0; k < 5; k++) exp_q.push_back({fl, asc(m[4*k+:4])});
      PMFC_NUM_PKG4: for (k = 0; k < 5; k++) begin
        exp_q.push_back(report ? {st, m[4*k+:4]} : {fl, 3'h6, m[4*k+:4]});
      end
      PMFC_RAW8: begin
        exp_q.push_back(m[7:0]);
        exp_q.push_back(m[15:8]);
        exp_q.push_back({st, m[19:16]});
      end
      default: begin
        // Leftover bits sit below the new codeword's bits
        b = (27'(m) << pend_n) | 27'(pend);
        f = fl | (pend_flag && pend_n > 0);
        for (k = pend_n + 20; k >= 7; k -= 7) begin
          exp_q.push_back({f, b[6:0]});
          b = b >> 7;
          f = fl;
        end
        pend = b[6:0];
        pend_n = k;
        pend_flag = fl;
      end
    endcase
  endtask : expect_cw

  // ==========================================================
  // Codeword driver and word comparison
  task automatic send_cw(input logic first, input logic [1:0] fn, input logic [19:0] m,
      input logic [3:0] st, input logic fl);
    int i;
    expect_cw(first, m, st, fl);
    @(posedge clock);
    cw_valid <= 1'b1;
    cw <= {first, fn, m, st, fl};
    for (i = 0; i < 200; i++) begin
      @(posedge clock);
      if (cw_ready) begin
        cw_valid <= 1'b0;
        return;
      end
    end
    timeout("codeword");
  endtask : send_cw

  task automatic drain();
    int i;
    for (i = 0; i < 400 && pmfc_host_model_i.got.size() < exp_q.size(); i++) begin
      @(posedge clock);
    end
    // Words still missing after the bound end the run
    if (pmfc_host_model_i.got.size() < exp_q.size()) begin
      timeout("message words");
    end
    repeat (4) @(posedge clock);
    check("word count", pmfc_host_model_i.got.size(), exp_q.size());
    while (exp_q.size() > 0 && pmfc_host_model_i.got.size() > 0) begin
      check("word", pmfc_host_model_i.got.pop_front(), exp_q.pop_front());
    end
    exp_q.delete();
    pmfc_host_model_i.got.delete();
  endtask : drain

  // ==========================================================
  // Main sequence
  initial begin
    rows = '{'{5'h00, 2'h0, PMFC_NUM_PKG4}, '{5'h08, 2'h0, PMFC_NUM_PKG4},
      '{5'h02, 2'h0, PMFC_NUM_ASCII}, '{5'h01, 2'h0, PMFC_ALPHA7},
      '{5'h03, 2'h0, PMFC_NUM_ASCII}, '{5'h03, 2'h1, PMFC_ALPHA7},
      '{5'h03, 2'h2, PMFC_ALPHA7}, '{5'h03, 2'h3, PMFC_ALPHA7},
      '{5'h04, 2'h1, PMFC_NUM_ASCII}, '{5'h05, 2'h0, PMFC_ALPHA7},
      '{5'h06, 2'h0, PMFC_ALPHA7}, '{5'h07, 2'h0, PMFC_ALPHA7}, '{5'h10, 2'h0, PMFC_RAW8}};
    {rst_n, cw_valid, stall, awvalid, wvalid, bready, arvalid, rready} = '0;
    {cw, awaddr, araddr, wdata, wstrb} = '0;
    {err_total, n_tests, pend_n, pend_flag, pend} = '0;
    repeat (4) @(posedge clock);
    check("reset outputs", {cw_ready, out_valid}, 2'h0);
    rst_n <= 1'b1;
    // Reset values, refused and unmapped accesses
    axi_write(PMFC_STATUS_OFFSET, 32'h1f, 4'hf, PMFC_RESP_OKAY);
    axi_write(PMFC_CTRL_OFFSET, 32'h1f, 4'he, PMFC_RESP_OKAY);
    axi_write(8'h0c, 32'h1f, 4'hf, PMFC_RESP_SLVERR);
    axi_read(PMFC_CTRL_OFFSET);
    check("ctrl", rd, 32'(PMFC_CTRL_RESET));
    check("ctrl resp", 32'(rsp), 32'(PMFC_RESP_OKAY));
    axi_read(8'h08);
    check("unmapped data", rd, 32'h0);
    check("unmapped resp", 32'(rsp), 32'(PMFC_RESP_SLVERR));
    // Format table: one message per row
    foreach (rows[r]) begin
      axi_write(PMFC_CTRL_OFFSET, 32'(rows[r].ctrl), 4'hf, PMFC_RESP_OKAY);
      cur_mode = rows[r].mode;
      report = rows[r].ctrl[3];
      stall <= r[0];
      send_cw(1'b1, rows[r].func, 20'h9a5c3 ^ 20'(r * 4951), 4'(r), r[1]);
      drain();
      axi_read(PMFC_STATUS_OFFSET);
      check("mode", 32'(rd[2:1]), 32'(rows[r].mode));
    end
    // Numeric message over four codewords, every nibble value
    axi_write(PMFC_CTRL_OFFSET, 32'h02, 4'hf, PMFC_RESP_OKAY);
    cur_mode = PMFC_NUM_ASCII;
    stall <= 1'b1;
    for (int k = 0; k < 4; k++) send_cw(k == 0, 2'h0, 20'h43210 + 20'(k) * 20'h55555, 4'h0, k[0]);
    drain();
    // Alphanumeric characters across codewords, leftovers dropped on a new message
    axi_write(PMFC_CTRL_OFFSET, 32'h01, 4'hf, PMFC_RESP_OKAY);
    cur_mode = PMFC_ALPHA7;
    for (int k = 0; k < 5; k++) send_cw(k == 0 || k == 4, 2'h0, 20'hc6b35 + 20'(k * 777), 4'h0, k == 1);
    drain();
    // Reset in mid-message
    axi_write(PMFC_CTRL_OFFSET, 32'h10, 4'hf, PMFC_RESP_OKAY);
    cur_mode = PMFC_RAW8;
    send_cw(1'b1, 2'h0, 20'h12345, 4'h5, 1'b0);
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    // Reset has been low for a whole cycle: outputs already cleared
    check("mid reset outputs", {cw_ready, out_valid}, 2'h0);
    rst_n <= 1'b1;
    exp_q.delete();
    pmfc_host_model_i.got.delete();
    axi_read(PMFC_STATUS_OFFSET);
    check("mode after reset", 32'(rd[2:1]), 32'(PMFC_NUM_PKG4));
    axi_read(PMFC_CTRL_OFFSET);
    check("ctrl after reset", rd, 32'(PMFC_CTRL_RESET));
    results();
  end
endmodule : tb_top
`default_nettype wire
